// >>> hw/clk_gate_bank_regs.svh
`ifndef CLK_GATE_BANK_REGS_SVH
`define CLK_GATE_BANK_REGS_SVH

// Register byte offsets
`define HSB_GATES_OFF    12'h014
`define FAST_GATES_OFF   12'h018
`define SLOW_GATES_OFF   12'h01C

// Reset values
`define HSB_GATES_RST    32'h0000_0014
`define FAST_GATES_RST   32'h0000_0000
`define SLOW_GATES_RST   32'h0000_0000

// Writable bits, reserved bits stay at reset value
`define HSB_GATES_MASK   32'h0000_17D5
`define FAST_GATES_MASK  32'h000E_7803
`define SLOW_GATES_MASK  32'h1262_08DF

// High-speed-bus gate bit positions
`define HSB_CONV_BIT     12
`define HSB_PORT_D_BIT   10
`define HSB_PORT_C_BIT   9
`define HSB_PORT_B_BIT   8
`define HSB_PORT_A_BIT   7
`define HSB_CSUM_BIT     6
`define HSB_FLASH_BIT    4
`define HSB_SRAM_BIT     2
`define HSB_DMA_BIT      0

// Fast peripheral-bus gate bit positions
`define FAST_SPI2_BIT    19
`define FAST_ASY4_BIT    18
`define FAST_ASY3_BIT    17
`define FAST_SA1_BIT     14
`define FAST_TMR8_BIT    13
`define FAST_SPI1_BIT    12
`define FAST_TMR1_BIT    11
`define FAST_TONE_BIT    1
`define FAST_ALTF_BIT    0

// Slow peripheral-bus gate bit positions
`define SLOW_PWR_BIT     28
`define SLOW_CAN_BIT     25
`define SLOW_TW2_BIT     22
`define SLOW_TW1_BIT     21
`define SLOW_SA2_BIT     17
`define SLOW_WDG_BIT     11
`define SLOW_CMPF_BIT    7
`define SLOW_CMP_BIT     6
`define SLOW_TMR6_BIT    4
`define SLOW_TMR5_BIT    3
`define SLOW_TMR4_BIT    2
`define SLOW_TMR3_BIT    1
`define SLOW_TMR2_BIT    0

`endif

// >>> hw/clk_gate_bank_pkg.sv
package clk_gate_bank_pkg;

	typedef logic [31:0] word_t;
	typedef logic [11:0] addr_t;

	typedef struct packed {
		logic  psel;
		logic  penable;
		logic  pwrite;
		addr_t paddr;
		word_t pwdata;
	} apb_req_s;

	typedef struct packed {
		logic converter_iface_clk_gate;
		logic port_d_clk_gate;
		logic port_c_clk_gate;
		logic port_b_clk_gate;
		logic port_a_clk_gate;
		logic checksum_unit_clk_gate;
		logic flash_interface_clk_run;
		logic sram_iface_clk_run;
		logic dma_ctrl_clk_gate;
	} hsb_gates_s;

	typedef struct packed {
		logic serial_periph2_clk_gate;
		logic async_port4_clk_gate;
		logic async_port3_clk_gate;
		logic sync_async_port1_clk_gate;
		logic timer_eight_clk_gate;
		logic serial_periph1_clk_gate;
		logic timer_one_clk_gate;
		logic tone_gen_clk_gate;
		logic altfunc_pin_cfg_clk_gate;
	} fast_gates_s;

	typedef struct packed {
		logic power_ctrl_clk_gate;
		logic can_ctrl_clk_gate;
		logic twowire2_clk_gate;
		logic twowire1_clk_gate;
		logic sync_async_port2_clk_gate;
		logic window_watchdog_clk_gate;
		logic comparator_filter_clk_gate;
		logic comparator_clk_gate;
		logic timer_six_clk_gate;
		logic timer_five_clk_gate;
		logic timer_four_clk_gate;
		logic timer_three_clk_gate;
		logic timer_two_clk_gate;
	} slow_gates_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RESP = 2'b10
	} apb_state_e;

endpackage : clk_gate_bank_pkg

// >>> hw/peripheral_clock_gate_bank.sv
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "clk_gate_bank_regs.svh"

module peripheral_clock_gate_bank
	import clk_gate_bank_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire apb_req_s    apb_req,
	input  wire logic        sleep_mode,
	output logic             pready,
	output logic             pslverr,
	output word_t            prdata,
	output hsb_gates_s       hsb_gates,
	output fast_gates_s      fast_gates,
	output slow_gates_s      slow_gates
);

	// One-hot register select: {slow, fast, hsb}
	function automatic logic [2:0] reg_select(input addr_t a);
		reg_select = {a == `SLOW_GATES_OFF, a == `FAST_GATES_OFF, a == `HSB_GATES_OFF};
	endfunction : reg_select

	// Writable bits from the bus, reserved bits forced to reset value
	function automatic word_t masked_write(input word_t wd, input word_t mask,
			input word_t rst_val);
		masked_write = (wd & mask) | (rst_val & ~mask);
	endfunction : masked_write

	apb_state_e  state_reg;
	apb_state_e  state_next;
	word_t       hsb_reg;
	word_t       hsb_next;
	word_t       fast_reg;
	word_t       fast_next;
	word_t       slow_reg;
	word_t       slow_next;
	logic        pready_next;
	logic        pslverr_next;
	word_t       prdata_next;
	hsb_gates_s  hsb_gates_next;
	fast_gates_s fast_gates_next;
	slow_gates_s slow_gates_next;
	logic [2:0]  sel;
	logic        access;
	logic        commit;

	assign sel    = reg_select(apb_req.paddr);
	assign access = apb_req.psel && apb_req.penable;
	assign commit = access && (state_reg == ST_RESP);

	// Bus slave: one wait cycle, then pready for one cycle
	always_comb begin
		state_next   = state_reg;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		prdata_next  = prdata;
		unique case (state_reg)
			ST_IDLE: begin
				if (access) begin
					state_next   = ST_RESP;
					pready_next  = 1'b1;
					pslverr_next = (sel == 3'b000);
					prdata_next  = (apb_req.pwrite) ? prdata :
						(({32{sel[0]}} & hsb_reg) |
						 ({32{sel[1]}} & fast_reg) |
						 ({32{sel[2]}} & slow_reg));
				end
			end
			ST_RESP: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Write lands at the completing edge; reserved bits kept at reset value
	always_comb begin
		hsb_next  = hsb_reg;
		fast_next = fast_reg;
		slow_next = slow_reg;
		if (commit && apb_req.pwrite) begin
			if (sel[0]) begin
				hsb_next = masked_write(apb_req.pwdata, `HSB_GATES_MASK,
					`HSB_GATES_RST);
			end
			if (sel[1]) begin
				fast_next = masked_write(apb_req.pwdata, `FAST_GATES_MASK,
					`FAST_GATES_RST);
			end
			if (sel[2]) begin
				slow_next = masked_write(apb_req.pwdata, `SLOW_GATES_MASK,
					`SLOW_GATES_RST);
			end
		end
	end

	// High-speed-bus gate enables, from next register values
	always_comb begin
		hsb_gates_next.converter_iface_clk_gate = hsb_next[`HSB_CONV_BIT];
		hsb_gates_next.port_d_clk_gate          = hsb_next[`HSB_PORT_D_BIT];
		hsb_gates_next.port_c_clk_gate          = hsb_next[`HSB_PORT_C_BIT];
		hsb_gates_next.port_b_clk_gate          = hsb_next[`HSB_PORT_B_BIT];
		hsb_gates_next.port_a_clk_gate          = hsb_next[`HSB_PORT_A_BIT];
		hsb_gates_next.checksum_unit_clk_gate   = hsb_next[`HSB_CSUM_BIT];
		hsb_gates_next.flash_interface_clk_run  =
			!sleep_mode || hsb_next[`HSB_FLASH_BIT];
		hsb_gates_next.sram_iface_clk_run       =
			!sleep_mode || hsb_next[`HSB_SRAM_BIT];
		hsb_gates_next.dma_ctrl_clk_gate        = hsb_next[`HSB_DMA_BIT];
	end

	// Fast peripheral-bus gate enables
	always_comb begin
		fast_gates_next.serial_periph2_clk_gate   = fast_next[`FAST_SPI2_BIT];
		fast_gates_next.serial_periph1_clk_gate   = fast_next[`FAST_SPI1_BIT];
		fast_gates_next.async_port4_clk_gate      = fast_next[`FAST_ASY4_BIT];
		fast_gates_next.async_port3_clk_gate      = fast_next[`FAST_ASY3_BIT];
		fast_gates_next.sync_async_port1_clk_gate = fast_next[`FAST_SA1_BIT];
		fast_gates_next.timer_eight_clk_gate      = fast_next[`FAST_TMR8_BIT];
		fast_gates_next.timer_one_clk_gate        = fast_next[`FAST_TMR1_BIT];
		fast_gates_next.tone_gen_clk_gate         = fast_next[`FAST_TONE_BIT];
		fast_gates_next.altfunc_pin_cfg_clk_gate  = fast_next[`FAST_ALTF_BIT];
	end

	// Slow peripheral-bus gate enables
	always_comb begin
		slow_gates_next.power_ctrl_clk_gate        = slow_next[`SLOW_PWR_BIT];
		slow_gates_next.can_ctrl_clk_gate          = slow_next[`SLOW_CAN_BIT];
		slow_gates_next.twowire2_clk_gate          = slow_next[`SLOW_TW2_BIT];
		slow_gates_next.twowire1_clk_gate          = slow_next[`SLOW_TW1_BIT];
		slow_gates_next.sync_async_port2_clk_gate  = slow_next[`SLOW_SA2_BIT];
		slow_gates_next.window_watchdog_clk_gate   = slow_next[`SLOW_WDG_BIT];
		slow_gates_next.comparator_filter_clk_gate = slow_next[`SLOW_CMPF_BIT];
		slow_gates_next.comparator_clk_gate        = slow_next[`SLOW_CMP_BIT];
		slow_gates_next.timer_six_clk_gate         = slow_next[`SLOW_TMR6_BIT];
		slow_gates_next.timer_five_clk_gate        = slow_next[`SLOW_TMR5_BIT];
		slow_gates_next.timer_four_clk_gate        = slow_next[`SLOW_TMR4_BIT];
		slow_gates_next.timer_three_clk_gate       = slow_next[`SLOW_TMR3_BIT];
		slow_gates_next.timer_two_clk_gate         = slow_next[`SLOW_TMR2_BIT];
	end

	// Bus answer registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			prdata    <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			pready    <= pready_next;
			pslverr   <= pslverr_next;
			prdata    <= prdata_next;
		end
	end

	// Gate registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hsb_reg  <= `HSB_GATES_RST;
			fast_reg <= `FAST_GATES_RST;
			slow_reg <= `SLOW_GATES_RST;
		end else begin
			hsb_reg  <= hsb_next;
			fast_reg <= fast_next;
			slow_reg <= slow_next;
		end
	end

	// Enables change only just after a rising edge, for a low-phase latch gate
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hsb_gates  <= '0;
			fast_gates <= '0;
			slow_gates <= '0;
		end else begin
			hsb_gates  <= hsb_gates_next;
			fast_gates <= fast_gates_next;
			slow_gates <= slow_gates_next;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	hsb_reset_val_a: assert property ($past(rst) |-> hsb_reg == `HSB_GATES_RST)
		else $error("hsb gate register reset value wrong");

	pbus_reset_zero_a: assert property ($past(rst) |-> fast_reg == 32'h0000_0000
		&& slow_reg == 32'h0000_0000 && slow_gates == '0 && fast_gates == '0)
		else $error("peripheral bus gates not cleared at reset");

	hsb_write_lands_a: assert property (commit && apb_req.pwrite && sel[0] |=>
		hsb_gates.converter_iface_clk_gate == $past(apb_req.pwdata[`HSB_CONV_BIT])
		&& hsb_gates.dma_ctrl_clk_gate == $past(apb_req.pwdata[`HSB_DMA_BIT]))
		else $error("converter or dma gate did not follow write");

	port_gates_a: assert property ({hsb_gates.port_d_clk_gate, hsb_gates.port_c_clk_gate,
		hsb_gates.port_b_clk_gate, hsb_gates.port_a_clk_gate} ==
		hsb_reg[`HSB_PORT_D_BIT:`HSB_PORT_A_BIT])
		else $error("port gates disagree with register");

	flash_sleep_a: assert property ($past(sleep_mode) && !$past(rst) |->
		hsb_gates.flash_interface_clk_run == hsb_reg[`HSB_FLASH_BIT])
		else $error("flash clock not following sleep bit");

	sram_awake_a: assert property (!$past(sleep_mode) && !$past(rst) |->
		hsb_gates.sram_iface_clk_run && hsb_gates.flash_interface_clk_run)
		else $error("memory clocks stopped outside sleep");

	fast_write_a: assert property (commit && apb_req.pwrite && sel[1] |=>
		fast_reg == ($past(apb_req.pwdata) & `FAST_GATES_MASK)
		&& fast_gates.serial_periph2_clk_gate == fast_reg[`FAST_SPI2_BIT])
		else $error("fast gate write not applied");

	slow_gates_a: assert property (slow_gates.can_ctrl_clk_gate == slow_reg[`SLOW_CAN_BIT]
		&& slow_gates.power_ctrl_clk_gate == slow_reg[`SLOW_PWR_BIT]
		&& slow_gates.timer_two_clk_gate == slow_reg[`SLOW_TMR2_BIT])
		else $error("slow gates disagree with register");

	gate_hold_a: assert property (!(commit && apb_req.pwrite) |=> $stable(fast_reg)
		&& $stable(slow_reg))
		else $error("gate register changed without a write");

	ready_pulse_a: assert property (access && !pready ##1 access |-> pready ##1 !pready)
		else $error("pready not a one-cycle answer");

	unmapped_err_a: assert property (access && !pready && sel == 3'b000 |=> pslverr)
		else $error("unmapped access not flagged");

	converter_gate_a: assert property (hsb_gates.converter_iface_clk_gate ==
		hsb_reg[`HSB_CONV_BIT])
		else $error("converter gate disagrees with register");

	csum_port_write_a: assert property (commit && apb_req.pwrite && sel[0] |=>
		hsb_gates.checksum_unit_clk_gate == $past(apb_req.pwdata[`HSB_CSUM_BIT])
		&& hsb_gates.port_a_clk_gate == $past(apb_req.pwdata[`HSB_PORT_A_BIT])
		&& hsb_gates.port_d_clk_gate == $past(apb_req.pwdata[`HSB_PORT_D_BIT]))
		else $error("checksum or port gate did not follow write");

	sram_sleep_a: assert property ($past(sleep_mode) && !$past(rst) |->
		hsb_gates.sram_iface_clk_run == hsb_reg[`HSB_SRAM_BIT])
		else $error("sram clock not following sleep bit");

	dma_gate_a: assert property (hsb_gates.dma_ctrl_clk_gate == hsb_reg[`HSB_DMA_BIT])
		else $error("dma gate disagrees with register");

	reserved_kept_a: assert property (
		((hsb_reg ^ `HSB_GATES_RST) & ~`HSB_GATES_MASK) == 32'h0000_0000
		&& ((fast_reg ^ `FAST_GATES_RST) & ~`FAST_GATES_MASK) == 32'h0000_0000
		&& ((slow_reg ^ `SLOW_GATES_RST) & ~`SLOW_GATES_MASK) == 32'h0000_0000)
		else $error("reserved gate bits left reset value");

	async_ports_write_a: assert property (commit && apb_req.pwrite && sel[1] |=>
		fast_gates.async_port4_clk_gate == $past(apb_req.pwdata[`FAST_ASY4_BIT])
		&& fast_gates.async_port3_clk_gate == $past(apb_req.pwdata[`FAST_ASY3_BIT]))
		else $error("async port gates did not follow write");

	sa1_gate_a: assert property (commit && apb_req.pwrite && sel[1] |=>
		fast_gates.sync_async_port1_clk_gate == $past(apb_req.pwdata[`FAST_SA1_BIT]))
		else $error("sync async port one gate did not follow write");

	fast_timers_a: assert property (commit && apb_req.pwrite && sel[1] |=>
		fast_gates.timer_eight_clk_gate == $past(apb_req.pwdata[`FAST_TMR8_BIT])
		&& fast_gates.timer_one_clk_gate == $past(apb_req.pwdata[`FAST_TMR1_BIT]))
		else $error("fast timer gates did not follow write");

	tone_gate_a: assert property (fast_gates.tone_gen_clk_gate == fast_reg[`FAST_TONE_BIT])
		else $error("tone gate disagrees with register");

	altfunc_gate_a: assert property (fast_gates.altfunc_pin_cfg_clk_gate ==
		fast_reg[`FAST_ALTF_BIT])
		else $error("alternate-function gate disagrees with register");

	power_gate_a: assert property (commit && apb_req.pwrite && sel[2] |=>
		slow_gates.power_ctrl_clk_gate == $past(apb_req.pwdata[`SLOW_PWR_BIT]))
		else $error("power control gate did not follow write");

	twowire_gates_a: assert property (slow_gates.twowire2_clk_gate == slow_reg[`SLOW_TW2_BIT]
		&& slow_gates.twowire1_clk_gate == slow_reg[`SLOW_TW1_BIT])
		else $error("two-wire gates disagree with register");

	port2_gate_a: assert property (slow_gates.sync_async_port2_clk_gate ==
		slow_reg[`SLOW_SA2_BIT])
		else $error("sync async port two gate disagrees with register");

	watchdog_gate_a: assert property (slow_gates.window_watchdog_clk_gate ==
		slow_reg[`SLOW_WDG_BIT])
		else $error("watchdog gate disagrees with register");

	comparator_gates_a: assert property (commit && apb_req.pwrite && sel[2] |=>
		slow_gates.comparator_filter_clk_gate == $past(apb_req.pwdata[`SLOW_CMPF_BIT])
		&& slow_gates.comparator_clk_gate == $past(apb_req.pwdata[`SLOW_CMP_BIT]))
		else $error("comparator gates did not follow write");

	slow_timers_a: assert property (commit && apb_req.pwrite && sel[2] |=>
		{slow_gates.timer_six_clk_gate, slow_gates.timer_five_clk_gate,
		 slow_gates.timer_four_clk_gate, slow_gates.timer_three_clk_gate,
		 slow_gates.timer_two_clk_gate} == $past(apb_req.pwdata[`SLOW_TMR6_BIT:`SLOW_TMR2_BIT]))
		else $error("slow timer gates did not follow write");

	unmapped_no_write_a: assert property (commit && sel == 3'b000 |=>
		$stable(hsb_reg) && $stable(fast_reg) && $stable(slow_reg))
		else $error("unmapped access changed a gate register");

	hsb_read_data_a: assert property (access && !pready && !apb_req.pwrite && sel[0] |=>
		prdata == $past(hsb_reg))
		else $error("high-speed gate read data wrong");

	fast_read_data_a: assert property (access && !pready && !apb_req.pwrite && sel[1] |=>
		prdata == $past(fast_reg))
		else $error("fast gate read data wrong");

	slow_read_data_a: assert property (access && !pready && !apb_req.pwrite && sel[2] |=>
		prdata == $past(slow_reg))
		else $error("slow gate read data wrong");

	pslverr_ready_a: assert property (pslverr |-> pready)
		else $error("error shown without ready");

	write_ack_a: assert property (commit |-> pready)
		else $error("transfer completed without ready");

	cov_hsb_write_c: cover property (commit && apb_req.pwrite && sel[0]);
	cov_fast_write_c: cover property (commit && apb_req.pwrite && sel[1]);
	cov_slow_read_c: cover property (commit && !apb_req.pwrite && sel[2]);
	cov_sleep_stop_c: cover property (sleep_mode && !hsb_reg[`HSB_SRAM_BIT]);
	cov_unmapped_c: cover property (pready && pslverr);

endmodule : peripheral_clock_gate_bank

// >>> verif/gated_clock_sink.sv
`timescale 1ns/10ps

module gated_clock_sink
	import clk_gate_bank_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire hsb_gates_s hsb_gates,
	output logic            dma_clk,
	output int unsigned     dma_edges
);
	logic        en_lat;
	int unsigned edge_cnt = 0;

	// Enable held transparent in low phase only, so no clipped pulse
	always_latch begin
		if (!clk_sys) begin
			en_lat <= hsb_gates.dma_ctrl_clk_gate;
		end
	end
	assign dma_clk = clk_sys & en_lat;

	always @(posedge dma_clk) begin
		edge_cnt++;
	end
	assign dma_edges = edge_cnt;
endmodule : gated_clock_sink

// >>> verif/peripheral_clock_gate_bank_test.sv
`timescale 1ns/10ps
`include "clk_gate_bank_regs.svh"

module peripheral_clock_gate_bank_test
	import clk_gate_bank_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	apb_req_s    apb_req = '0;
	logic        sleep_mode = 1'b0;
	logic        pready;
	logic        pslverr;
	word_t       prdata;
	hsb_gates_s  hsb_gates;
	fast_gates_s fast_gates;
	slow_gates_s slow_gates;
	logic        dma_clk;
	int unsigned dma_edges;
	int          miscompares = 0;
	int          n_tests = 0;
	int          cycles = 0;

	peripheral_clock_gate_bank uut (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
		.sleep_mode(sleep_mode), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.hsb_gates(hsb_gates), .fast_gates(fast_gates), .slow_gates(slow_gates));
	gated_clock_sink sink (.clk_sys(clk_sys), .hsb_gates(hsb_gates), .dma_clk(dma_clk),
		.dma_edges(dma_edges));

	always #5 clk_sys = ~clk_sys;

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			miscompares++;
		end
	endtask : check

	task automatic apb_xfer(input addr_t a, input logic w, input word_t wd,
			output word_t d, output logic e);
		@(posedge clk_sys);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		// Ready looked at mid-cycle, so the next rising edge completes
		do begin
			@(negedge clk_sys);
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		@(posedge clk_sys);
		apb_req <= '0;
	endtask : apb_xfer

	task automatic wr(input addr_t a, input word_t wd);
		word_t d;
		logic  e;
		apb_xfer(a, 1'b1, wd, d, e);
		check("write error", 32'h0, 32'(e));
	endtask : wr

	task automatic rd_check(input addr_t a, input word_t exp, input logic exp_err);
		word_t d;
		logic  e;
		apb_xfer(a, 1'b0, 32'h0, d, e);
		check("read data", exp, d);
		check("read error", 32'(exp_err), 32'(e));
	endtask : rd_check

	task automatic test_reset_values;
		rd_check(`HSB_GATES_OFF, 32'h0000_0014, 1'b0);
		rd_check(`FAST_GATES_OFF, 32'h0000_0000, 1'b0);
		rd_check(`SLOW_GATES_OFF, 32'h0000_0000, 1'b0);
		@(negedge clk_sys);
		check("reset gates", 32'h0000_0006, {23'h0, hsb_gates});
		check("reset fast slow", 32'h0, 32'({fast_gates, slow_gates}));
		$display("test reset values done");
	endtask : test_reset_values

	task automatic walk_reg(input addr_t a, input int n, input int pos[13]);
		logic [12:0] got;
		for (int i = 0; i < n; i++) begin
			wr(a, 32'h1 << pos[i]);
			rd_check(a, 32'h1 << pos[i], 1'b0);
			@(negedge clk_sys);
			got = (a == `HSB_GATES_OFF) ? 13'(hsb_gates) :
				(a == `FAST_GATES_OFF) ? 13'(fast_gates) : 13'(slow_gates);
			check("gate output", 32'(13'h1 << (n - 1 - i)), 32'(got));
		end
	endtask : walk_reg

	task automatic test_walk;
		@(posedge clk_sys);
		sleep_mode <= 1'b1;
		walk_reg(`HSB_GATES_OFF, 9, '{12, 10, 9, 8, 7, 6, 4, 2, 0, 0, 0, 0, 0});
		walk_reg(`FAST_GATES_OFF, 9, '{19, 18, 17, 14, 13, 12, 11, 1, 0, 0, 0, 0, 0});
		walk_reg(`SLOW_GATES_OFF, 13, '{28, 25, 22, 21, 17, 11, 7, 6, 4, 3, 2, 1, 0});
		$display("test walking bits done");
	endtask : test_walk

	task automatic test_reserved;
		wr(`HSB_GATES_OFF, 32'hFFFF_FFFF);
		wr(`FAST_GATES_OFF, 32'hFFFF_FFFF);
		wr(`SLOW_GATES_OFF, 32'hFFFF_FFFF);
		rd_check(`HSB_GATES_OFF, 32'h0000_17D5, 1'b0);
		rd_check(`FAST_GATES_OFF, 32'h000E_7803, 1'b0);
		rd_check(`SLOW_GATES_OFF, 32'h1262_08DF, 1'b0);
		rd_check(12'h020, 32'h0, 1'b1);
		rd_check(12'h010, 32'h0, 1'b1);
		rd_check(`HSB_GATES_OFF, 32'h0000_17D5, 1'b0);
		$display("test reserved and unmapped done");
	endtask : test_reserved

	task automatic test_sleep;
		int unsigned e0;
		@(posedge clk_sys);
		sleep_mode <= 1'b0;
		wr(`HSB_GATES_OFF, 32'h0000_0001);
		@(negedge clk_sys);
		check("awake run", 32'h3, {hsb_gates.flash_interface_clk_run, hsb_gates.sram_iface_clk_run});
		@(posedge clk_sys);
		sleep_mode <= 1'b1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		check("sleep run", 32'h0, {hsb_gates.flash_interface_clk_run, hsb_gates.sram_iface_clk_run});
		wr(`HSB_GATES_OFF, 32'h0000_0010);
		@(negedge clk_sys);
		check("flash kept", 32'h2, {hsb_gates.flash_interface_clk_run, hsb_gates.sram_iface_clk_run});
		e0 = dma_edges;
		repeat (4) @(negedge clk_sys);
		check("stopped edges", 32'd0, 32'(dma_edges - e0));
		wr(`HSB_GATES_OFF, 32'h0000_0005);
		@(negedge clk_sys);
		check("sram kept", 32'h1, {hsb_gates.flash_interface_clk_run, hsb_gates.sram_iface_clk_run});
		e0 = dma_edges;
		repeat (4) @(negedge clk_sys);
		check("gated edges", 32'd4, 32'(dma_edges - e0));
		$display("test sleep done");
	endtask : test_sleep

	task automatic test_mid_reset;
		wr(`FAST_GATES_OFF, 32'hFFFF_FFFF);
		@(posedge clk_sys);
		rst <= 1'b1;
		sleep_mode <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		test_reset_values();
		$display("test mid-run reset done");
	endtask : test_mid_reset

	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		test_reset_values();
		test_walk();
		test_reserved();
		test_sleep();
		test_mid_reset();
		wrap_up();
	end
endmodule : peripheral_clock_gate_bank_test
